// [src/dmd_decode.sv]
// data and program memory address decoder
//
// Behaviour
// [RULE_01] low 128 bytes: direct and indirect
// [RULE_02] indirect upper half selects upper RAM
// [RULE_03] direct upper half selects special space
// [RULE_04] first 32 bytes: four register banks
// [RULE_05] next 16 bytes byte or bit addressable
// [RULE_06] on-chip 4k block repeats every 4k
// [RULE_07] external map: onchip, offchip or split
// [RULE_08] external port muxed or separate lines
// [RULE_09] 64k flash erased in 512-byte sectors
// [RULE_10] software avoids reserved flash FE00-FFFF
// [RULE_11] extra 128-byte sector at 10000-1007F
// [RULE_12] onchip mode uses low twelve address bits
`timescale 1ns/100ps
module dmd_decode (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // configuration
  input wire dmd_pkg::dmd_xmap_t xmap_i,
  input wire logic muxed_i,
  input wire logic [1:0] bank_sel_i,
  // internal data access
  input wire dmd_pkg::dmd_iacc_t iacc_i,
  // external data access
  input wire dmd_pkg::dmd_xacc_t xacc_i,
  // program access
  input wire dmd_pkg::dmd_pacc_t pacc_i,
  // internal data decode
  output logic iram_sel_o,
  output logic [7:0] iram_addr_o,
  output logic [2:0] iram_bit_o,
  output logic special_sel_o,
  output logic [6:0] special_addr_o,
  output dmd_pkg::dmd_itgt_t itgt_o,
  // on-chip xram
  output logic xram_sel_o,
  output logic xram_we_o,
  output logic [11:0] xram_addr_o,
  output logic [7:0] xram_wdata_o,
  // external_memory_port pins
  output logic [7:0] ext_ad_o,
  output logic ext_ad_oe_o,
  output logic [7:0] ext_addr_hi_o,
  output logic [7:0] ext_addr_lo_o,
  output logic [7:0] ext_data_o,
  output logic ext_data_oe_o,
  output logic ext_ale_o,
  output logic ext_wr_n_o,
  output logic ext_rd_n_o,
  // flash decode
  output logic flash_sel_o,
  output logic [15:0] flash_addr_o,
  output logic [6:0] flash_sector_o,
  output logic flash_rsvd_o,
  output logic scratch_sel_o,
  output logic [6:0] scratch_addr_o
);
  import dmd_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic xram_hit(input dmd_xmap_t m,
                                    input logic [15:0] a);
    unique case (m)
      DMD_MAP_ONCHIP: xram_hit = 1'b1; // [RULE_07]
      DMD_MAP_OFFCHIP: xram_hit = 1'b0; // [RULE_07]
      default: xram_hit = (a < DMD_XRAM_SIZE); // [RULE_07]
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // internal data space
  // ----------------------------------------------------------------------
  logic isel_d, isel_q, ssel_d, ssel_q;
  logic [7:0] iaddr_d, iaddr_q;
  logic [2:0] ibit_d, ibit_q;
  logic [6:0] saddr_d, saddr_q;
  dmd_itgt_t itgt_d, itgt_q;

  always_comb begin
    isel_d = 1'b0;
    ssel_d = 1'b0;
    iaddr_d = 8'h00;
    ibit_d = 3'h0;
    saddr_d = 7'h00;
    itgt_d = itgt_q;
    if (iacc_i.valid) begin
      if (iacc_i.bit_mode) begin
        // bit numbers below 0x80 land in the 16-byte bit area
        if (!iacc_i.addr[7]) begin // [RULE_05]
          isel_d = 1'b1;
          iaddr_d = DMD_BIT_BYTE_BASE + {4'h0, iacc_i.addr[6:3]};
          ibit_d = iacc_i.addr[2:0];
          itgt_d = DMD_TGT_LOW_RAM;
        end else begin
          ssel_d = 1'b1;
          saddr_d = {iacc_i.addr[6:3], 3'h0};
          ibit_d = iacc_i.addr[2:0];
          itgt_d = DMD_TGT_SPECIAL;
        end
      end else if (!iacc_i.addr[7]) begin // [RULE_01]
        isel_d = 1'b1;
        itgt_d = DMD_TGT_LOW_RAM;
        // register-bank access lifts r0..r7 into the selected bank
        iaddr_d = iacc_i.addr;
        if (iacc_i.addr <= DMD_BANK_TOP) begin // [RULE_04]
          iaddr_d = {3'h0, bank_sel_i, iacc_i.addr[2:0]};
        end
      end else if (iacc_i.indirect) begin // [RULE_02]
        isel_d = 1'b1;
        iaddr_d = iacc_i.addr;
        itgt_d = DMD_TGT_HIGH_RAM;
      end else begin // [RULE_03]
        ssel_d = 1'b1;
        saddr_d = iacc_i.addr[6:0];
        itgt_d = DMD_TGT_SPECIAL;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      isel_q <= 1'b0;
      ssel_q <= 1'b0;
      iaddr_q <= 8'h00;
      ibit_q <= 3'h0;
      saddr_q <= 7'h00;
      itgt_q <= DMD_TGT_LOW_RAM;
    end else begin
      isel_q <= isel_d;
      ssel_q <= ssel_d;
      iaddr_q <= iaddr_d;
      ibit_q <= ibit_d;
      saddr_q <= saddr_d;
      itgt_q <= itgt_d;
    end
  end

  // ----------------------------------------------------------------------
  // external data space
  // ----------------------------------------------------------------------
  logic xsel_d, xsel_q, xwe_d, xwe_q, go_ext;
  logic [11:0] xaddr_d, xaddr_q;
  logic [7:0] xwd_d, xwd_q;

  assign go_ext = xacc_i.valid && !xram_hit(xmap_i, xacc_i.addr);

  always_comb begin
    xsel_d = 1'b0;
    xwe_d = 1'b0;
    xaddr_d = 12'h000;
    xwd_d = 8'h00;
    if (xacc_i.valid && xram_hit(xmap_i, xacc_i.addr)) begin
      xsel_d = 1'b1;
      xwe_d = xacc_i.we;
      // upper bits dropped, so the block aliases every 4k
      xaddr_d = xacc_i.addr[DMD_XRAM_AW-1:0]; // [RULE_06] [RULE_12]
      xwd_d = xacc_i.wdata;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      xsel_q <= 1'b0;
      xwe_q <= 1'b0;
      xaddr_q <= 12'h000;
      xwd_q <= 8'h00;
    end else begin
      xsel_q <= xsel_d;
      xwe_q <= xwe_d;
      xaddr_q <= xaddr_d;
      xwd_q <= xwd_d;
    end
  end

  dmd_xport u_xport (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .go_i(go_ext),
    .muxed_i(muxed_i),
    .we_i(xacc_i.we),
    .addr_i(xacc_i.addr),
    .wdata_i(xacc_i.wdata),
    .ad_o(ext_ad_o),
    .ad_oe_o(ext_ad_oe_o),
    .addr_hi_o(ext_addr_hi_o),
    .addr_lo_o(ext_addr_lo_o),
    .data_o(ext_data_o),
    .data_oe_o(ext_data_oe_o),
    .ale_o(ext_ale_o),
    .wr_n_o(ext_wr_n_o),
    .rd_n_o(ext_rd_n_o)
  );

  // ----------------------------------------------------------------------
  // program flash space
  // ----------------------------------------------------------------------
  logic fsel_d, fsel_q, rsvd_d, rsvd_q, ssc_d, ssc_q;
  logic [15:0] faddr_d, faddr_q;
  logic [6:0] fsec_d, fsec_q, scaddr_d, scaddr_q;

  always_comb begin
    fsel_d = 1'b0;
    rsvd_d = 1'b0;
    ssc_d = 1'b0;
    faddr_d = 16'h0000;
    fsec_d = 7'h00;
    scaddr_d = 7'h00;
    if (pacc_i.valid) begin
      if (pacc_i.addr <= DMD_FLASH_TOP) begin
        fsel_d = 1'b1;
        faddr_d = pacc_i.addr[15:0];
        fsec_d = pacc_i.addr[15:DMD_SECTOR_SHIFT]; // [RULE_09]
        // flagged only; the core's firmware is expected to stay out
        rsvd_d = (pacc_i.addr >= DMD_RSVD_BASE); // [RULE_10]
      end else if (pacc_i.addr >= DMD_SCRATCH_BASE &&
                   pacc_i.addr <= DMD_SCRATCH_TOP) begin // [RULE_11]
        ssc_d = 1'b1;
        scaddr_d = pacc_i.addr[6:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fsel_q <= 1'b0;
      rsvd_q <= 1'b0;
      ssc_q <= 1'b0;
      faddr_q <= 16'h0000;
      fsec_q <= 7'h00;
      scaddr_q <= 7'h00;
    end else begin
      fsel_q <= fsel_d;
      rsvd_q <= rsvd_d;
      ssc_q <= ssc_d;
      faddr_q <= faddr_d;
      fsec_q <= fsec_d;
      scaddr_q <= scaddr_d;
    end
  end

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  assign iram_sel_o = isel_q;
  assign iram_addr_o = iaddr_q;
  assign iram_bit_o = ibit_q;
  assign special_sel_o = ssel_q;
  assign special_addr_o = saddr_q;
  assign itgt_o = itgt_q;
  assign xram_sel_o = xsel_q;
  assign xram_we_o = xwe_q;
  assign xram_addr_o = xaddr_q;
  assign xram_wdata_o = xwd_q;
  assign flash_sel_o = fsel_q;
  assign flash_addr_o = faddr_q;
  assign flash_sector_o = fsec_q;
  assign flash_rsvd_o = rsvd_q;
  assign scratch_sel_o = ssc_q;
  assign scratch_addr_o = scaddr_q;
endmodule

// [common/dmd_pkg.sv]
// package for the data memory address decoder
package dmd_pkg;

  // ----------------------------------------------------------------------
  // internal data space
  // ----------------------------------------------------------------------
  localparam logic [7:0] DMD_BANK_TOP = 8'h1F;
  localparam logic [7:0] DMD_BITAREA_BASE = 8'h20;
  localparam logic [7:0] DMD_BITAREA_TOP = 8'h2F;
  localparam logic [7:0] DMD_BIT_BYTE_BASE = 8'h20;

  // ----------------------------------------------------------------------
  // external data space
  // ----------------------------------------------------------------------
  localparam int DMD_XRAM_AW = 12;
  localparam logic [15:0] DMD_XRAM_SIZE = 16'h1000;

  // ----------------------------------------------------------------------
  // program flash space
  // ----------------------------------------------------------------------
  localparam logic [16:0] DMD_FLASH_TOP = 17'h0_FFFF;
  localparam logic [16:0] DMD_RSVD_BASE = 17'h0_FE00;
  localparam logic [16:0] DMD_SCRATCH_BASE = 17'h1_0000;
  localparam logic [16:0] DMD_SCRATCH_TOP = 17'h1_007F;
  localparam int DMD_SECTOR_SHIFT = 9;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DMD_MAP_ONCHIP,
    DMD_MAP_OFFCHIP,
    DMD_MAP_SPLIT,
    DMD_MAP_SPLIT_ALT
  } dmd_xmap_t;

  typedef enum logic [1:0] {
    DMD_TGT_LOW_RAM,
    DMD_TGT_HIGH_RAM,
    DMD_TGT_SPECIAL
  } dmd_itgt_t;

  typedef struct packed {
    logic valid;
    logic indirect;
    logic bit_mode;
    logic [7:0] addr;
  } dmd_iacc_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dmd_xacc_t;

  typedef struct packed {
    logic valid;
    logic [16:0] addr;
  } dmd_pacc_t;

endpackage

// [src/dmd_xport.sv]
// external memory port address and data line driver
`timescale 1ns/100ps
module dmd_xport (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // access
  input wire logic go_i,
  input wire logic muxed_i,
  input wire logic we_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  // pins
  output logic [7:0] ad_o,
  output logic ad_oe_o,
  output logic [7:0] addr_hi_o,
  output logic [7:0] addr_lo_o,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic ale_o,
  output logic wr_n_o,
  output logic rd_n_o
);
  import dmd_pkg::*;

  logic [7:0] ad_d, ad_q, hi_d, hi_q, lo_d, lo_q, dat_d, dat_q;
  logic adoe_d, adoe_q, doe_d, doe_q, ale_d, ale_q;
  logic wrn_d, wrn_q, rdn_d, rdn_q;

  // multiplexed mode puts the low address and data on one byte lane,
  // so the lane carries the address when ale is high and data otherwise
  always_comb begin
    ad_d = 8'h00;
    adoe_d = 1'b0;
    hi_d = hi_q;
    lo_d = 8'h00;
    dat_d = 8'h00;
    doe_d = 1'b0;
    ale_d = 1'b0;
    wrn_d = 1'b1;
    rdn_d = 1'b1;
    if (go_i) begin
      hi_d = addr_i[15:8];
      wrn_d = ~we_i;
      rdn_d = we_i;
      if (muxed_i) begin // [RULE_08]
        ad_d = we_i ? wdata_i : addr_i[7:0];
        adoe_d = 1'b1;
        ale_d = ~we_i;
      end else begin // [RULE_08]
        lo_d = addr_i[7:0];
        dat_d = wdata_i;
        doe_d = we_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ad_q <= 8'h00;
      adoe_q <= 1'b0;
      hi_q <= 8'h00;
      lo_q <= 8'h00;
      dat_q <= 8'h00;
      doe_q <= 1'b0;
      ale_q <= 1'b0;
      wrn_q <= 1'b1;
      rdn_q <= 1'b1;
    end else begin
      ad_q <= ad_d;
      adoe_q <= adoe_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
      dat_q <= dat_d;
      doe_q <= doe_d;
      ale_q <= ale_d;
      wrn_q <= wrn_d;
      rdn_q <= rdn_d;
    end
  end

  assign ad_o = ad_q;
  assign ad_oe_o = adoe_q;
  assign addr_hi_o = hi_q;
  assign addr_lo_o = lo_q;
  assign data_o = dat_q;
  assign data_oe_o = doe_q;
  assign ale_o = ale_q;
  assign wr_n_o = wrn_q;
  assign rd_n_o = rdn_q;
endmodule

// [tb/dmd_decode_asserts.sv]
// concurrent checks on the decoder ports
`timescale 1ns/100ps
module dmd_decode_asserts (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // configuration and requests
  input wire dmd_pkg::dmd_xmap_t xmap_i,
  input wire logic muxed_i,
  input wire logic [1:0] bank_sel_i,
  input wire dmd_pkg::dmd_iacc_t iacc_i,
  input wire dmd_pkg::dmd_xacc_t xacc_i,
  input wire dmd_pkg::dmd_pacc_t pacc_i,
  // decode results
  input wire logic iram_sel_o,
  input wire logic [7:0] iram_addr_o,
  input wire logic [2:0] iram_bit_o,
  input wire logic special_sel_o,
  input wire logic [6:0] special_addr_o,
  input wire logic xram_sel_o,
  input wire logic [11:0] xram_addr_o,
  input wire logic [7:0] ext_ad_o,
  input wire logic ext_ad_oe_o,
  input wire logic ext_data_oe_o,
  input wire logic ext_ale_o,
  input wire logic ext_wr_n_o,
  input wire logic ext_rd_n_o,
  input wire logic flash_sel_o,
  input wire logic [6:0] flash_sector_o,
  input wire logic scratch_sel_o,
  input wire logic [6:0] scratch_addr_o
);
  import dmd_pkg::*;
  // ----
  // helpers
  // ----
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  wire [7:0] ia = iacc_i.addr;
  wire [15:0] xa = xacc_i.addr;
  wire [16:0] pa = pacc_i.addr;
  wire iv = iacc_i.valid && !iacc_i.bit_mode;
  AST_LOW_BOTH: assert property (
    iv && ia inside {[8'h20:8'h7F]} |=> iram_sel_o && iram_addr_o == $past(ia))
    else $error("low ram decode wrong");
  AST_HIGH_IND: assert property (
    iv && iacc_i.indirect && ia[7] |=> iram_sel_o && !special_sel_o
    && iram_addr_o == $past(ia)) else $error("upper ram decode wrong");
  AST_SPECIAL: assert property (
    iv && !iacc_i.indirect && ia[7] |=> special_sel_o && !iram_sel_o
    && special_addr_o == $past(ia[6:0])) else $error("special decode wrong");
  AST_BANK: assert property (
    iv && ia <= DMD_BANK_TOP |=>
    iram_addr_o == {3'h0, $past(bank_sel_i), $past(ia[2:0])})
    else $error("bank remap wrong");
  AST_BIT: assert property (
    iacc_i.valid && iacc_i.bit_mode && !ia[7] |=> iram_bit_o == $past(ia[2:0])
    && iram_addr_o == DMD_BIT_BYTE_BASE + $past(ia[6:3]))
    else $error("bit decode wrong");
  AST_ONCHIP: assert property (
    xacc_i.valid && xmap_i == DMD_MAP_ONCHIP |=> xram_sel_o && ext_rd_n_o
    && xram_addr_o == $past(xa[11:0])) else $error("onchip decode wrong");
  AST_OFFCHIP: assert property (
    xacc_i.valid && !xacc_i.we && xmap_i == DMD_MAP_OFFCHIP |=>
    !xram_sel_o && !ext_rd_n_o && ext_wr_n_o) else $error("offchip wrong");
  AST_SPLIT: assert property (
    xacc_i.valid && xmap_i inside {DMD_MAP_SPLIT, DMD_MAP_SPLIT_ALT} |=>
    xram_sel_o == ($past(xa) < DMD_XRAM_SIZE)) else $error("split wrong");
  AST_MUX_READ: assert property (
    xacc_i.valid && !xacc_i.we && xmap_i == DMD_MAP_OFFCHIP && muxed_i |=>
    ext_ale_o && ext_ad_oe_o && ext_ad_o == $past(xa[7:0]))
    else $error("muxed read lane wrong");
  AST_SEP_WRITE: assert property (
    xacc_i.valid && xacc_i.we && xmap_i == DMD_MAP_OFFCHIP && !muxed_i |=>
    ext_data_oe_o && !ext_ad_oe_o && !ext_wr_n_o)
    else $error("separate write lines wrong");
  AST_FLASH: assert property (
    pacc_i.valid && !pa[16] |=> flash_sel_o && !scratch_sel_o
    && flash_sector_o == $past(pa[15:9])) else $error("sector wrong");
  AST_SCRATCH: assert property (
    pacc_i.valid && pa inside {[DMD_SCRATCH_BASE:DMD_SCRATCH_TOP]} |=>
    scratch_sel_o && !flash_sel_o && scratch_addr_o == $past(pa[6:0]))
    else $error("scratch wrong");
endmodule

// [tb/dmd_core.sv]
// processor core model issuing decoder requests
`timescale 1ns/100ps
module dmd_core (
  // clock
  input wire logic clk_sys_i,
  // requests
  output dmd_pkg::dmd_iacc_t iacc_o,
  output dmd_pkg::dmd_xacc_t xacc_o,
  output dmd_pkg::dmd_pacc_t pacc_o
);
  import dmd_pkg::*;
  // ----
  // requests, each held to the next falling edge
  // ----
  task automatic idle();
    iacc_o = '0;
    xacc_o = '0;
    pacc_o = '0;
    @(negedge clk_sys_i);
  endtask
  task automatic iacc(input logic ind, bm, input logic [7:0] a);
    iacc_o = {1'b1, ind, bm, a};
    @(negedge clk_sys_i);
  endtask
  task automatic xacc(input logic we, input logic [15:0] a,
                      input logic [7:0] d);
    xacc_o = {1'b1, we, a, d};
    @(negedge clk_sys_i);
  endtask
  // factory range is only touched when a test asks for it
  task automatic pacc(input logic [16:0] a, input logic fac);
    if (a[16:9] == 8'h7F && !fac) return;
    pacc_o = {1'b1, a};
    @(negedge clk_sys_i);
  endtask
  initial begin
    iacc_o = '0;
    xacc_o = '0;
    pacc_o = '0;
  end
endmodule

// [tb/tb_top.sv]
// self-checking testbench for the address decoder
`timescale 1ns/100ps
module tb_top;
  import dmd_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  dmd_xmap_t xmap_i = DMD_MAP_ONCHIP;
  logic muxed_i = 1'b0;
  logic [1:0] bank_sel_i = 2'h0;
  dmd_iacc_t iacc_i;
  dmd_xacc_t xacc_i;
  dmd_pacc_t pacc_i;
  dmd_itgt_t itgt_o;
  logic iram_sel_o, special_sel_o, xram_sel_o, xram_we_o, ext_ad_oe_o;
  logic ext_data_oe_o, ext_ale_o, ext_wr_n_o, ext_rd_n_o;
  logic flash_sel_o, flash_rsvd_o, scratch_sel_o;
  logic [7:0] iram_addr_o, xram_wdata_o, ext_ad_o, ext_addr_hi_o;
  logic [7:0] ext_addr_lo_o, ext_data_o;
  logic [2:0] iram_bit_o;
  logic [6:0] special_addr_o, flash_sector_o, scratch_addr_o;
  logic [11:0] xram_addr_o;
  logic [15:0] flash_addr_o;
  int errors = 0;
  int comparisons = 0;

  always #5 clk_sys_i = ~clk_sys_i;
  dmd_decode u_dmd_decode (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .xmap_i(xmap_i),
    .muxed_i(muxed_i),
    .bank_sel_i(bank_sel_i),
    .iacc_i(iacc_i),
    .xacc_i(xacc_i),
    .pacc_i(pacc_i),
    .iram_sel_o(iram_sel_o),
    .iram_addr_o(iram_addr_o),
    .iram_bit_o(iram_bit_o),
    .special_sel_o(special_sel_o),
    .special_addr_o(special_addr_o),
    .itgt_o(itgt_o),
    .xram_sel_o(xram_sel_o),
    .xram_we_o(xram_we_o),
    .xram_addr_o(xram_addr_o),
    .xram_wdata_o(xram_wdata_o),
    .ext_ad_o(ext_ad_o),
    .ext_ad_oe_o(ext_ad_oe_o),
    .ext_addr_hi_o(ext_addr_hi_o),
    .ext_addr_lo_o(ext_addr_lo_o),
    .ext_data_o(ext_data_o),
    .ext_data_oe_o(ext_data_oe_o),
    .ext_ale_o(ext_ale_o),
    .ext_wr_n_o(ext_wr_n_o),
    .ext_rd_n_o(ext_rd_n_o),
    .flash_sel_o(flash_sel_o),
    .flash_addr_o(flash_addr_o),
    .flash_sector_o(flash_sector_o),
    .flash_rsvd_o(flash_rsvd_o),
    .scratch_sel_o(scratch_sel_o),
    .scratch_addr_o(scratch_addr_o)
  );
  dmd_core u_dmd_core (.clk_sys_i(clk_sys_i), .iacc_o(iacc_i),
    .xacc_o(xacc_i), .pacc_o(pacc_i));

  // ----
  // helpers
  // ----
  task automatic chk(input logic [16:0] s, e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("Error %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_iram();
    for (int b = 0; b < 4; b++) begin
      bank_sel_i = b[1:0];
      u_dmd_core.iacc(1'b0, 1'b0, 8'h1D);
      chk(iram_addr_o, {b[1:0], 3'h5});
    end
    for (int m = 0; m < 2; m++) begin
      u_dmd_core.iacc(m[0], 1'b0, 8'h7F);
      chk({iram_sel_o, iram_addr_o}, 9'h17F);
      u_dmd_core.iacc(m[0], 1'b0, 8'h80);
      chk({special_sel_o, iram_sel_o}, {!m[0], m[0]});
    end
    u_dmd_core.iacc(1'b0, 1'b0, 8'h90);
    chk(special_addr_o, 7'h10);
    u_dmd_core.iacc(1'b1, 1'b0, 8'hFF);
    chk(iram_addr_o, 8'hFF);
    chk(itgt_o, DMD_TGT_HIGH_RAM);
    u_dmd_core.iacc(1'b0, 1'b1, 8'h7F);
    chk({iram_addr_o, iram_bit_o}, {8'h2F, 3'h7});
    chk(itgt_o, DMD_TGT_LOW_RAM);
    u_dmd_core.iacc(1'b0, 1'b1, 8'h8B);
    chk({special_sel_o, special_addr_o, iram_bit_o}, 11'h443);
    chk(itgt_o, DMD_TGT_SPECIAL);
    u_dmd_core.idle();
    $display("internal ram test done");
  endtask

  task automatic t_xdata();
    u_dmd_core.xacc(1'b1, 16'hF234, 8'hA5);
    chk({xram_sel_o, xram_we_o, xram_addr_o}, 14'h3234);
    chk({ext_wr_n_o, xram_wdata_o}, 9'h1A5);
    xmap_i = DMD_MAP_OFFCHIP;
    muxed_i = 1'b1;
    u_dmd_core.xacc(1'b0, 16'h0234, 8'h00);
    chk(xram_sel_o, 1'b0);
    chk({ext_ale_o, ext_rd_n_o, ext_ad_o}, {2'h2, 8'h34});
    chk({ext_ad_oe_o, ext_data_oe_o}, 2'h2);
    u_dmd_core.xacc(1'b1, 16'h0234, 8'h3C);
    chk({ext_ale_o, ext_wr_n_o, ext_ad_oe_o, ext_ad_o}, 11'h13C);
    muxed_i = 1'b0;
    u_dmd_core.xacc(1'b1, 16'hABCD, 8'h5A);
    chk({ext_wr_n_o, ext_addr_lo_o, ext_data_o}, 17'h0_CD5A);
    chk(ext_addr_hi_o, 8'hAB);
    chk({ext_data_oe_o, ext_ad_oe_o}, 2'h2);
    for (int m = 2; m < 4; m++) begin
      xmap_i = dmd_xmap_t'(m[1:0]);
      u_dmd_core.xacc(1'b0, 16'h0FFF, 8'h00);
      chk({xram_sel_o, xram_addr_o}, 13'h1FFF);
      u_dmd_core.xacc(1'b0, 16'h1000, 8'h00);
      chk({xram_sel_o, ext_rd_n_o}, 2'h0);
    end
    u_dmd_core.idle();
    $display("external data test done");
  endtask

  task automatic t_flash();
    u_dmd_core.pacc(17'h0_0200, 1'b0);
    chk({flash_sel_o, flash_addr_o}, 17'h1_0200);
    chk(flash_sector_o, 7'h01);
    u_dmd_core.pacc(17'h0_FDFF, 1'b0);
    chk({flash_sector_o, flash_rsvd_o}, {7'h7E, 1'b0});
    u_dmd_core.pacc(17'h0_FE00, 1'b1);
    chk(flash_rsvd_o, 1'b1);
    u_dmd_core.pacc(17'h1_007F, 1'b0);
    chk({scratch_sel_o, flash_sel_o, scratch_addr_o}, 9'h17F);
    u_dmd_core.pacc(17'h1_0080, 1'b0);
    chk({scratch_sel_o, flash_sel_o}, 2'h0);
    u_dmd_core.idle();
    $display("program space test done");
  endtask

  // ----
  // main sequence and hang guard
  // ----
  initial begin
    repeat (10) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    @(negedge clk_sys_i);
    chk({ext_rd_n_o, ext_wr_n_o, iram_sel_o}, 3'h6);
    t_iram();
    t_xdata();
    t_flash();
    complete_run();
  end
  initial begin
    #500000;
    errors++;
    complete_run();
  end
endmodule

bind dmd_decode dmd_decode_asserts u_dmd_decode_asserts (
  .clk_sys_i(clk_sys_i),
  .reset_n_i(reset_n_i),
  .xmap_i(xmap_i),
  .muxed_i(muxed_i),
  .bank_sel_i(bank_sel_i),
  .iacc_i(iacc_i),
  .xacc_i(xacc_i),
  .pacc_i(pacc_i),
  .iram_sel_o(iram_sel_o),
  .iram_addr_o(iram_addr_o),
  .iram_bit_o(iram_bit_o),
  .special_sel_o(special_sel_o),
  .special_addr_o(special_addr_o),
  .xram_sel_o(xram_sel_o),
  .xram_addr_o(xram_addr_o),
  .ext_ad_o(ext_ad_o),
  .ext_ad_oe_o(ext_ad_oe_o),
  .ext_data_oe_o(ext_data_oe_o),
  .ext_ale_o(ext_ale_o),
  .ext_wr_n_o(ext_wr_n_o),
  .ext_rd_n_o(ext_rd_n_o),
  .flash_sel_o(flash_sel_o),
  .flash_sector_o(flash_sector_o),
  .scratch_sel_o(scratch_sel_o),
  .scratch_addr_o(scratch_addr_o)
);
